// ### design/rli_top.sv
// Restart interlock latches: single or gated restart latch and pre-arm latch.
// Assumes asynchronous pushbutton and safety pins and an AXI4-Lite master.
`timescale 1ns/10ps
module rli_top #(
  parameter int TICK_CYCLES = rli_pkg::TICK_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [6:0]  permit_in,
  input  wire logic [6:0]  restart_in,
  input  wire logic        clear_in,
  input  wire logic        pre_arm_pulse,
  input  wire logic        arm_pulse,
  input  wire logic        protect_in,
  output      logic        latch_q,
  output      logic        rearm_req,
  output      logic        gate_out,
  output      logic        prearm_q,
  output      logic        prearm_req
);
  import rli_pkg::*;

  // Pre-arm sequence states.
  typedef enum logic [2:0] {
    PS_IDLE, PS_PRE_HI, PS_WINDOW, PS_ARM_HI, PS_SET
  } rli_pre_st_t;

  // Evaluates a gate over the first cnt inputs; a count of 0 or 1 bypasses.
  function automatic logic gate_eval(input logic [6:0] v,
                                     input logic [2:0] cnt,
                                     input logic [2:0] fn);
    logic [6:0] m;
    logic       r;
    m = 7'h7f >> (3'h7 - cnt);
    r = v[0];
    if (cnt > 3'h1) begin
      case (fn)
        GF_AND:  r = &(v | ~m);
        GF_NAND: r = ~&(v | ~m);
        GF_OR:   r = |(v & m);
        GF_NOR:  r = ~|(v & m);
        GF_XOR:  r = ^(v & m);
        GF_XNOR: r = ~^(v & m);
        default: r = &(v | ~m);
      endcase
    end
    return r;
  endfunction : gate_eval

  logic [17:0] ctrl_q;          // Latch configuration.
  logic [12:0] precfg_q;        // Pre-arm configuration.
  logic [18:0] sy1_q;           // First synchroniser stage.
  logic [18:0] sy2_q;           // Second synchroniser stage.
  logic [31:0] tick_cnt_q;      // Divider for the system tick.
  logic        tick_q;          // One-cycle system tick.
  logic [3:0]  blink_cnt_q;     // Ticks within a blink half period.
  logic        blink_q;         // Shared 1 Hz blink level.
  logic        rst_prev_q;      // Restart level one cycle ago.
  logic        rst_seen_q;      // Monitored restart has risen.
  logic        pb_prev_q;       // Pre-arm button one cycle ago.
  logic        ab_prev_q;       // Arm button one cycle ago.
  logic        prot_prev_q;     // Protective input one cycle ago.
  logic [6:0]  pulse_tk_q;      // Ticks a button has been held.
  logic [3:0]  sec_tk_q;        // Ticks within the current second.
  logic [6:0]  win_s_q;         // Seconds spent in the window.
  logic [2:0]  intr_q;          // Interruptions seen in the window.
  logic        intr_ovf_q;      // Interruption count passed the limit.
  rli_pre_st_t pst_q;           // Pre-arm sequence state.
  logic        aw_ok_q;         // Pending write was to a mapped address.

  // Synchronised pins.
  logic [6:0]  perm_s;
  logic [6:0]  rst_s;
  logic        clr_pin_s;
  logic        pb_s;
  logic        ab_s;
  logic        prot_s;
  assign perm_s    = sy2_q[6:0];
  assign rst_s     = sy2_q[13:7];
  assign clr_pin_s = sy2_q[14];
  assign pb_s      = sy2_q[15];
  assign ab_s      = sy2_q[16];
  assign prot_s    = sy2_q[17];

  // Derived latch signals.
  logic       clr_act;
  logic       pre_clr;
  logic       perm_g;
  logic       rst_g;
  logic       rst_rise;
  logic       rst_fall;
  logic       qual;
  logic [6:0] win_s;
  logic [2:0] blk_lim;
  logic       arm_ok;

  assign clr_act = ctrl_q[CTRL_CLR_EN] & clr_pin_s;
  assign pre_clr = precfg_q[PRE_CLR_EN] & clr_pin_s;
  // Single latches use input 0; macro latches gate the inputs.
  assign perm_g = ctrl_q[CTRL_MACRO] ? gate_eval(perm_s,
                    ctrl_q[CTRL_PCNT_LO +: 3], ctrl_q[CTRL_PFN_LO +: 3])
                  : perm_s[0];
  assign rst_g  = ctrl_q[CTRL_MACRO] ? gate_eval(rst_s,
                    ctrl_q[CTRL_RCNT_LO +: 3], ctrl_q[CTRL_RFN_LO +: 3])
                  : rst_s[0];
  assign rst_rise = rst_g & ~rst_prev_q;
  assign rst_fall = ~rst_g & rst_prev_q;
  // Manual mode qualifies on the rise, monitored on the later fall.
  assign qual = ctrl_q[CTRL_MONITORED] ? (rst_fall & rst_seen_q)
                                       : rst_rise;
  // Window clamped to its legal range.
  assign win_s = (precfg_q[PRE_WIN_LO +: 7] < WIN_MIN_S) ? WIN_MIN_S :
                 (precfg_q[PRE_WIN_LO +: 7] > WIN_MAX_S) ? WIN_MAX_S :
                 precfg_q[PRE_WIN_LO +: 7];
  assign blk_lim = (precfg_q[PRE_BLK_LO +: 3] == 3'h0) ? 3'h1
                   : precfg_q[PRE_BLK_LO +: 3];
  // Arming needs the mandatory interruption and, for a limit above 1, no excess of the limit.
  assign arm_ok = ~(precfg_q[PRE_BLK_MAND] & (intr_q == 3'h0))
                  & ~((blk_lim != 3'h1) & intr_ovf_q);

  // Two-stage synchroniser for every asynchronous pin.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sy1_q <= '0;
      sy2_q <= '0;
    end else begin
      sy1_q <= {1'b0, protect_in, arm_pulse, pre_arm_pulse, clear_in,
                restart_in, permit_in};
      sy2_q <= sy1_q;
    end
  end

  // Common system tick that times pulses, windows and blinking.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
      tick_q     <= 1'b0;
    end
  end

  // Shared 1 Hz blink derived from the tick, not from latch inputs.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blink_cnt_q <= '0;
      blink_q     <= 1'b0;
    end else if (tick_q) begin
      if (blink_cnt_q == BLINK_TK - 4'h1) begin
        blink_cnt_q <= '0;
        blink_q     <= ~blink_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + 4'h1;
      end
    end
  end

  // Restart edge tracking for the latch.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_prev_q <= 1'b0;
      rst_seen_q <= 1'b0;
    end else begin
      rst_prev_q <= rst_g;
      if (clr_act || !perm_g || rst_fall) begin
        rst_seen_q <= 1'b0;
      end else if (rst_rise) begin
        rst_seen_q <= 1'b1;
      end
    end
  end

  // Restart latch, its rearm request and the gate result output.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_q   <= 1'b0;
      rearm_req <= 1'b0;
      gate_out  <= 1'b0;
    end else begin
      if (clr_act || !perm_g) begin
        latch_q <= 1'b0;
      end else if (qual) begin
        latch_q <= 1'b1;
      end
      gate_out <= ctrl_q[CTRL_MACRO] & ctrl_q[CTRL_GOUT_EN] & perm_g;
      if (!ctrl_q[CTRL_RR_EN]) begin
        rearm_req <= 1'b0;
      end else if (clr_act || !perm_g) begin
        // Type 2 shows high while blocked; type 1 and macro show low.
        rearm_req <= ctrl_q[CTRL_RR_TYPE2] & ~ctrl_q[CTRL_MACRO];
      end else if (latch_q) begin
        rearm_req <= 1'b0;
      end else if (ctrl_q[CTRL_RR_TYPE2] && !ctrl_q[CTRL_MACRO]) begin
        rearm_req <= blink_q;
      end else begin
        rearm_req <= 1'b1;
      end
    end
  end

  // Button and protective input history for edge detection.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pb_prev_q   <= 1'b0;
      ab_prev_q   <= 1'b0;
      prot_prev_q <= 1'b0;
    end else begin
      pb_prev_q   <= pb_s;
      ab_prev_q   <= ab_s;
      prot_prev_q <= prot_s;
    end
  end

  // Pre-arm sequence: timed pre-arm pulse, window, timed arm pulse.
  always_ff @(posedge aclk) begin
    if (!aresetn || pre_clr) begin
      pst_q      <= PS_IDLE;
      pulse_tk_q <= '0;
      sec_tk_q   <= '0;
      win_s_q    <= '0;
      intr_q     <= '0;
      intr_ovf_q <= 1'b0;
    end else begin
      case (pst_q)
        PS_IDLE: begin
          pulse_tk_q <= '0;
          if (pb_s && !pb_prev_q) begin
            pst_q <= PS_PRE_HI;
          end
        end
        PS_PRE_HI: begin
          if (tick_q && pulse_tk_q != 7'h7f) begin
            pulse_tk_q <= pulse_tk_q + 7'h1;
          end
          if (!pb_s) begin
            // Only a completed pulse no longer than the limit counts.
            if (pulse_tk_q <= PULSE_MAX_TK) begin
              pst_q <= PS_WINDOW;
            end else begin
              pst_q <= PS_IDLE;
            end
            sec_tk_q   <= '0;
            win_s_q    <= '0;
            intr_q     <= '0;
            intr_ovf_q <= 1'b0;
          end
        end
        PS_WINDOW, PS_ARM_HI: begin
          // Window seconds run on through the arm pulse.
          if (tick_q) begin
            if (sec_tk_q == SEC_TK - 4'h1) begin
              sec_tk_q <= '0;
              win_s_q  <= win_s_q + 7'h1;
            end else begin
              sec_tk_q <= sec_tk_q + 4'h1;
            end
          end
          // Count interruptions of the protective input.
          if (!prot_s && prot_prev_q) begin
            if (intr_q == blk_lim) begin
              intr_ovf_q <= 1'b1;
            end else begin
              intr_q <= intr_q + 3'h1;
            end
          end
          if (win_s_q >= win_s) begin
            pst_q <= PS_IDLE;
          end else if (pst_q == PS_WINDOW) begin
            pulse_tk_q <= '0;
            if (ab_s && !ab_prev_q) begin
              pst_q <= PS_ARM_HI;
            end
          end else begin
            if (tick_q && pulse_tk_q != 7'h7f) begin
              pulse_tk_q <= pulse_tk_q + 7'h1;
            end
            if (!ab_s) begin
              if (pulse_tk_q <= PULSE_MAX_TK && arm_ok) begin
                pst_q <= PS_SET;
              end else begin
                pst_q <= PS_WINDOW;
              end
            end
          end
        end
        PS_SET: begin
          // A new pre-arm restarts the whole sequence.
          if (pb_s && !pb_prev_q) begin
            pst_q      <= PS_PRE_HI;
            pulse_tk_q <= '0;
          end
        end
        default: begin
          pst_q <= PS_IDLE;
        end
      endcase
    end
  end

  // Pre-arm outputs follow the sequence state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prearm_q   <= 1'b0;
      prearm_req <= 1'b0;
    end else begin
      prearm_q   <= (pst_q == PS_SET) & ~pre_clr;
      prearm_req <= precfg_q[PRE_RR_EN] & ~pre_clr
                    & ((pst_q == PS_WINDOW) | (pst_q == PS_ARM_HI));
    end
  end

  // Write channel: address and data taken together in one cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_ok_q       <= 1'b0;
    end else begin
      s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid
                       & ~s_axi_awready;
      s_axi_wready  <= s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid
                       & ~s_axi_awready;
      aw_ok_q       <= (s_axi_awaddr[7:0] == ADDR_CTRL)
                       | (s_axi_awaddr[7:0] == ADDR_PRECFG)
                       | (s_axi_awaddr[7:0] == ADDR_STATUS);
    end
  end

  // Configuration registers with byte strobes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q   <= CTRL_RST;
      precfg_q <= PRECFG_RST;
    end else if (s_axi_awready) begin
      for (int b = 0; b < 3; b++) begin
        if (s_axi_wstrb[b] && s_axi_awaddr[7:0] == ADDR_CTRL) begin
          for (int i = 0; i < 8; i++) begin
            if (8 * b + i < CTRL_WIDTH) begin
              ctrl_q[8 * b + i] <= s_axi_wdata[8 * b + i];
            end
          end
        end
        if (s_axi_wstrb[b] && s_axi_awaddr[7:0] == ADDR_PRECFG) begin
          for (int i = 0; i < 8; i++) begin
            if (8 * b + i < PRE_WIDTH) begin
              precfg_q[8 * b + i] <= s_axi_wdata[8 * b + i];
            end
          end
        end
      end
    end
  end

  // Write response follows the cycle in which both were taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (s_axi_awready) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= aw_ok_q ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel with status showing live latch state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready;
      if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        case (s_axi_araddr[7:0])
          ADDR_CTRL:   s_axi_rdata <= {14'h0, ctrl_q};
          ADDR_PRECFG: s_axi_rdata <= {19'h0, precfg_q};
          ADDR_STATUS: s_axi_rdata <= {18'h0, intr_ovf_q, intr_q,
                                       5'(pst_q), gate_out, prearm_req,
                                       prearm_q, rearm_req, latch_q};
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : rli_top

// ### design/rli_pkg.sv
// Constants shared by the restart interlock latch design.
// Assumes a 25 MHz system clock and an AXI4-Lite master for configuration.
// Overview of operation
// - Clear or no permissive forces latch low.
// - Manual mode sets on restart rising edge.
// - Monitored mode sets after rise then fall.
// - Clear input ignored unless clear enabled.
// - Rearm request type 1 or type 2.
// - Type 2 blinking uses shared system timer.
// - Macro latches gate permissive and restart inputs.
// - Permissive gate 1 to 7 inputs, 1 bypasses.
// - Permissive gate AND NAND OR NOR XOR XNOR.
// - Restart gate 1 to 7 inputs, 1 bypasses.
// - Restart gate function selected independently.
// - Optional output carries permissive gate result.
// - Macro rearm request high only while waiting.
// - Pre-arm latch needs pre-arm then arm.
// - Pulses longer than 5s are rejected.
// - Arm accepted within 6 to 120s window.
// - Mandatory option needs one protective interruption.
// - Interruption limit 2 to 7 enforced; a limit of 1 never blocks arming.
// - Pre-arm request high from pre-arm to window end.
package rli_pkg;
  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_PRECFG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  // Control register field positions.
  localparam int CTRL_MONITORED = 0;
  localparam int CTRL_CLR_EN    = 1;
  localparam int CTRL_RR_EN     = 2;
  localparam int CTRL_RR_TYPE2  = 3;
  localparam int CTRL_MACRO     = 4;
  localparam int CTRL_GOUT_EN   = 5;
  localparam int CTRL_PCNT_LO   = 6;
  localparam int CTRL_PFN_LO    = 9;
  localparam int CTRL_RCNT_LO   = 12;
  localparam int CTRL_RFN_LO    = 15;
  localparam int CTRL_WIDTH     = 18;
  // Pre-arm configuration field positions.
  localparam int PRE_WIN_LO     = 0;
  localparam int PRE_BLK_MAND   = 7;
  localparam int PRE_BLK_LO     = 8;
  localparam int PRE_RR_EN      = 11;
  localparam int PRE_CLR_EN     = 12;
  localparam int PRE_WIDTH      = 13;
  // Reset values: single input manual latch, 6 s window, limit 1.
  localparam logic [17:0] CTRL_RST   = 18'h00000;
  localparam logic [12:0] PRECFG_RST = 13'h0106;
  // Window limits in seconds.
  localparam logic [6:0] WIN_MIN_S = 7'h06;
  localparam logic [6:0] WIN_MAX_S = 7'h78;
  // Timer tick period, clock period and derived tick figures.
  localparam int CLK_NS      = 40;
  localparam int TICK_MS     = 100;
  localparam int TICK_CYC    = TICK_MS * 1000000 / CLK_NS;
  localparam int TICKS_PER_S = 1000 / TICK_MS;
  localparam int PULSE_MAX_S = 5;
  localparam logic [6:0] PULSE_MAX_TK = 7'(PULSE_MAX_S * TICKS_PER_S);
  localparam int BLINK_HALF_MS = 500;
  localparam logic [3:0] BLINK_TK = 4'(BLINK_HALF_MS / TICK_MS);
  localparam logic [3:0] SEC_TK   = 4'(TICKS_PER_S);
  // Gate functions.
  typedef enum logic [2:0] {
    GF_AND  = 3'h0,
    GF_NAND = 3'h1,
    GF_OR   = 3'h2,
    GF_NOR  = 3'h3,
    GF_XOR  = 3'h4,
    GF_XNOR = 3'h5
  } rli_gate_fn_t;
  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : rli_pkg

// ### tb/rli_checker.sv
// Port-level checker for the restart interlock latches.
// Assumes it is bound to rli_top and shares its clock and reset.
`timescale 1ns/10ps
module rli_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        latch_q,
  input wire logic        rearm_req,
  input wire logic        prearm_q,
  input wire logic        prearm_req
);
  // All checks run on the one system clock and pause during reset.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A write is taken only after both address and data were offered.
  chk_aw_cause: assert property (s_axi_awready |->
    $past(s_axi_awvalid) && $past(s_axi_wvalid)) else $error("aw unasked");
  // Address and data are taken in the same cycle.
  chk_aw_w_pair: assert property (s_axi_awready == s_axi_wready)
    else $error("aw and w apart");
  // Each take is a single-cycle pulse.
  chk_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready too long");
  // A write response follows the take by one cycle.
  chk_b_follows: assert property ($rose(s_axi_bvalid) |->
    $past(s_axi_awready)) else $error("bvalid unprompted");
  // The response is withdrawn once accepted.
  chk_b_drop: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid) else $error("bvalid kept");
  // Read data comes with the address take, which lasts one cycle.
  chk_r_with_ar: assert property ($rose(s_axi_arready) |->
    s_axi_rvalid ##1 !s_axi_arready) else $error("read answer late");
  // A read is taken only when one was offered.
  chk_ar_cause: assert property ($rose(s_axi_arready) |->
    $past(s_axi_arvalid)) else $error("ar unasked");
  // Read data is withdrawn once accepted.
  chk_r_drop: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid) else $error("rvalid kept");
  // A set latch no longer asks for a restart.
  chk_req_low_set: assert property (latch_q [*2] |-> !rearm_req)
    else $error("rearm request while set");
  // Arming happens only inside an open window.
  chk_arm_in_win: assert property ($rose(prearm_q) |-> $past(prearm_req))
    else $error("armed outside window");
  // The window request ends once armed.
  chk_req_off_set: assert property (prearm_q [*2] |-> !prearm_req)
    else $error("window request while armed");
endmodule : rli_checker

bind rli_top rli_checker chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .latch_q, .rearm_req, .prearm_q,
  .prearm_req);

// ### tb/rli_operator.sv
// Operator model: pre-arm and arm pushbuttons and the protective input.
// Assumes tasks are called just after a rising clock edge.
`timescale 1ns/10ps
module rli_operator (
  input  wire logic aclk,
  output      logic pre_arm_pulse,
  output      logic arm_pulse,
  output      logic protect_in
);
  // Buttons rest released and the protective field rests unbroken.
  initial begin
    pre_arm_pulse = 1'b0;
    arm_pulse     = 1'b0;
    protect_in    = 1'b1;
  end
  // One whole press: rise, hold len cycles, fall, then settle.
  task automatic press(input bit arm, input int len);
    if (arm) arm_pulse <= 1'b1;
    else pre_arm_pulse <= 1'b1;
    repeat (len) @(posedge aclk);
    arm_pulse     <= 1'b0;
    pre_arm_pulse <= 1'b0;
    repeat (40) @(posedge aclk);
  endtask : press
  // One interruption of the protective field.
  task automatic interrupt();
    protect_in <= 1'b0;
    repeat (8) @(posedge aclk);
    protect_in <= 1'b1;
    repeat (8) @(posedge aclk);
  endtask : interrupt
endmodule : rli_operator

// ### tb/testbench.sv
// Self-checking bench for the restart interlock latches.
// Assumes a short tick parameter so window times fit in the run.
`timescale 1ns/10ps
module testbench;
  import rli_pkg::*;
  localparam int TK = 10; // Cycles per tick in simulation.
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, clear_in, s_axi_awready;
  logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        latch_q, rearm_req, gate_out, prearm_q, prearm_req;
  logic        pre_arm_pulse, arm_pulse, protect_in, ep, eq, b;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [3:0]  s_axi_wstrb;
  logic [6:0]  permit_in, restart_in, pv, r1, r2;
  logic [2:0]  pc, rc, pf, rf;
  int          failures, cmp_count, i, k;
  // Design under test with a shortened tick.
  rli_top #(.TICK_CYCLES(TK)) dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .permit_in,
    .restart_in, .clear_in, .pre_arm_pulse, .arm_pulse, .protect_in,
    .latch_q, .rearm_req, .gate_out, .prearm_q, .prearm_req);
  // Operator buttons on the far side.
  rli_operator op (.aclk, .pre_arm_pulse, .arm_pulse, .protect_in);
  // Free-running 25 MHz clock.
  always #20 aclk = ~aclk;
  // Prints the counts and the verdict, then stops.
  task automatic results();
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results
  // Compares one value and reports a mismatch.
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask : chk
  // Waits whole cycles.
  task automatic cyc(input int c);
    repeat (c) @(posedge aclk);
  endtask : cyc
  // One write; response ready stays high throughout.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cyc(1);
    s_axi_awaddr  <= {24'h0, a};
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    for (k = 0; k < 64 && !(s_axi_bvalid && !s_axi_awvalid); k++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      rsp = s_axi_bresp;
    end
    if (k == 64) begin
      failures++;
      results();
    end
  endtask : wr
  // One read; data ready stays high throughout.
  task automatic rdr(input logic [7:0] a);
    cyc(1);
    s_axi_araddr  <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    for (k = 0; k < 64 && !s_axi_rvalid; k++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      rd  = s_axi_rdata;
      rsp = s_axi_rresp;
    end
    if (k == 64) begin
      failures++;
      results();
    end
  endtask : rdr
  // Expected gate result over the first c inputs.
  function automatic logic gf(input logic [2:0] f, c, input logic [6:0] v);
    logic [6:0] m;
    m = (7'h1 << c) - 7'h1;
    if (c <= 3'h1) return v[0];
    case (f)
      3'h1: return ~&(v | ~m);
      3'h2: return |(v & m);
      3'h3: return ~|(v & m);
      3'h4: return ^(v & m);
      3'h5: return ~^(v & m);
      default: return &(v | ~m);
    endcase
  endfunction : gf
  // Main sequence.
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, clear_in} = 4'h0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hf;
    {permit_in, restart_in} = '0;
    {failures, cmp_count} = '0;
    void'($urandom(4782));
    cyc(2);
    aresetn <= 1'b1;
    rdr(ADDR_CTRL);
    chk("ctrl", {14'h0, CTRL_RST}, rd);
    rdr(ADDR_PRECFG);
    chk("precfg", {19'h0, PRECFG_RST}, rd);
    rdr(8'h0c);
    chk("rresp", RESP_SLVERR, rsp);
    wr(8'h10, 32'hffffffff);
    chk("bresp", RESP_SLVERR, rsp);
    $display("test registers done");
    wr(ADDR_CTRL, 32'h4);
    permit_in <= 7'h1;
    cyc(6);
    chk("q_idle", 0, latch_q);
    chk("req_wait", 1, rearm_req);
    restart_in <= 7'h1;
    cyc(6);
    chk("q_rise", 1, latch_q);
    clear_in <= 1'b1;
    cyc(6);
    chk("q_noclr", 1, latch_q);
    wr(ADDR_CTRL, 32'h6);
    cyc(6);
    chk("q_clr", 0, latch_q);
    clear_in <= 1'b0;
    restart_in <= 7'h0;
    cyc(6);
    chk("q_fall", 0, latch_q);
    restart_in <= 7'h1;
    cyc(6);
    chk("q_again", 1, latch_q);
    permit_in <= 7'h0;
    cyc(6);
    chk("q_noperm", 0, latch_q);
    wr(ADDR_CTRL, 32'h1);
    restart_in <= 7'h0;
    permit_in <= 7'h1;
    cyc(6);
    restart_in <= 7'h1;
    cyc(6);
    chk("mon_high", 0, latch_q);
    restart_in <= 7'h0;
    cyc(6);
    chk("mon_low", 1, latch_q);
    $display("test single latch done");
    wr(ADDR_CTRL, 32'hc);
    permit_in <= 7'h0;
    cyc(6);
    chk("t2_noperm", 1, rearm_req);
    permit_in <= 7'h1;
    cyc(6);
    b = rearm_req;
    k = 0;
    for (i = 0; i < 300; i++) begin
      @(posedge aclk);
      if (rearm_req !== b) k++;
      b = rearm_req;
    end
    chk("blink", 1, k >= 5 && k <= 7);
    $display("test blink done");
    for (i = 0; i < 18; i++) begin
      pc = (i == 0) ? 3'h1 : (i == 1) ? 3'h7 : 3'($urandom_range(7, 1));
      rc = (i == 2) ? 3'h1 : 3'($urandom_range(7, 1));
      pf = 3'(i % 6);
      rf = 3'((i / 3) % 6);
      pv = 7'($urandom());
      r1 = 7'($urandom());
      r2 = 7'($urandom());
      wr(ADDR_CTRL, {14'h0, rf, rc, pf, pc, 6'h36});
      clear_in <= 1'b1;
      permit_in <= pv;
      restart_in <= r1;
      cyc(6);
      clear_in <= 1'b0;
      cyc(6);
      restart_in <= r2;
      cyc(6);
      ep = gf(pf, pc, pv);
      eq = ep & ~gf(rf, rc, r1) & gf(rf, rc, r2);
      chk("gate", ep, gate_out);
      chk("macro_q", eq, latch_q);
      chk("macro_req", ep & ~eq, rearm_req);
    end
    $display("test macro done");
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_PRECFG, 32'h1806);
    op.press(1, 20);
    chk("arm_alone", 0, prearm_q);
    op.press(0, 20);
    chk("win_open", 1, prearm_req);
    op.press(1, 20);
    chk("armed", 1, prearm_q);
    chk("win_shut", 0, prearm_req);
    rdr(ADDR_STATUS);
    chk("status", 12'h021, rd[13:2]);
    clear_in <= 1'b1;
    cyc(6);
    chk("pre_clr", 0, prearm_q);
    clear_in <= 1'b0;
    op.press(0, 600);
    chk("long", 0, prearm_req);
    op.press(0, 20);
    cyc(700);
    chk("expired", 0, prearm_req);
    op.press(1, 20);
    chk("stale", 0, prearm_q);
    wr(ADDR_PRECFG, 32'h1a86);
    op.press(0, 20);
    op.press(1, 20);
    chk("no_int", 0, prearm_q);
    op.interrupt();
    op.press(1, 20);
    chk("int_ok", 1, prearm_q);
    op.press(0, 20);
    repeat (3) op.interrupt();
    op.press(1, 20);
    chk("over_limit", 0, prearm_q);
    $display("test pre-arm done");
    results();
  end
endmodule : testbench
